// [src/pmc_pkg.sv]
package pmc_pkg;

	// =====================================
	// Register offsets
	localparam logic [11:0] OFS_FIXED_LAT_TASK = 12'h078;
	localparam logic [11:0] OFS_ECONOMY_TASK   = 12'h07C;
	localparam logic [11:0] OFS_RESET_CAUSE    = 12'h400;
	localparam logic [11:0] OFS_DEEP_SLEEP     = 12'h500;
	localparam logic [11:0] OFS_SWITCHER_EN    = 12'h578;
	localparam logic [11:0] OFS_RAM_POWER0     = 12'h900;
	localparam logic [11:0] OFS_RAM_STRIDE     = 12'h010;
	localparam logic [11:0] OFS_STATUS         = 12'h5F0;

	// =====================================
	// Field positions
	localparam int RC_PIN_RESET  = 0;
	localparam int RC_SOFT_RESET = 1;
	localparam int RC_WAKE_SENSE = 2;
	localparam int RC_WAKE_DEBUG = 3;
	localparam int RAMP_POWER    = 0;
	localparam int RAMP_RETAIN   = 1;
	localparam int ST_SWITCHER   = 0;
	localparam int ST_FIXED_LAT  = 1;
	localparam int ST_DEBUG      = 2;
	localparam int ST_EMULATED   = 3;
	localparam int ST_IDLE_OK    = 4;

	// =====================================
	// Reset values
	localparam logic [3:0]  RESET_CAUSE_RST = 4'h0;
	localparam logic [1:0]  RAM_POWER_RST   = 2'h3;
	localparam logic [31:0] PSLVERR_NONE    = 32'h0000_0000;

	typedef enum logic [2:0] {
		PMC_ON       = 3'b001,
		PMC_DEEP_OFF = 3'b010,
		PMC_EMULATED = 3'b100
	} pmc_state_t;

	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} pmc_apb_req_t;

	typedef struct packed {
		logic regulator_switcher;
		logic fixed_latency;
		logic basic_resources_on;
		logic core_power_on;
	} pmc_power_t;

endpackage : pmc_pkg

// [src/pmc_power_mode_controller.sv]
// Operation
// - Linear regulator selected after reset by default
// - Switcher used only when software enables it
// - Deep sleep command write enters deep off
// - Entering deep off aborts all running tasks
// - Deep off wakes only on sense, debugger power request or power-on reset
// - Every wake from deep off resets device
// - Retained RAM sections keep contents in deep off
// - RAM power controls survive deep off, warm resets
// - Debug mode only emulates deep off
// - Emulation keeps debug, clock, power, memory alive
// - Power-on reset enters on state
// - Reset cause register records last wake source
// - On state powers sources following peripheral activity
// - Idle sub-modes apply only when all idle
// - Fixed latency task keeps basic resources on
// - Economy task selects efficient variable latency
// - On state entry starts in economy sub-mode
// - Debug mode follows debugger power request level
// - Deep off wake in debug keeps debug port
`timescale 1ns/1ps
module pmc_power_mode_controller
	import pmc_pkg::*;
#(
	parameter int RAM_SECTIONS = 3
) (
	input  wire logic                      CLK,
	input  wire logic                      RST,
	input  wire logic                      POR,
	input  wire logic                      PIN_RESET,
	input  wire logic                      SOFT_RESET,
	input  wire logic                      PIN_SENSE,
	input  wire logic                      DEBUGGER_POWER_REQUEST,
	input  wire logic                      CPU_IDLE,
	input  wire logic                      PERIPH_IDLE,
	input  wire logic                      PERIPH_ACTIVITY,
	input  wire logic                      PSEL,
	input  wire logic                      PENABLE,
	input  wire logic                      PWRITE,
	input  wire logic [11:0]               PADDR,
	input  wire logic [31:0]               PWDATA,
	output logic      [31:0]               PRDATA,
	output logic                           PREADY,
	output logic                           PSLVERR,
	output logic                           REGULATOR_SWITCHER,
	output logic                           CORE_POWER_ON,
	output logic                           BASIC_RESOURCES_ON,
	output logic                           FIXED_LATENCY_MODE,
	output logic                           TASK_ABORT,
	output logic                           SYSTEM_RESET,
	output logic                           DEBUG_PORT_RESET,
	output logic                           DEBUG_MODE,
	output logic      [RAM_SECTIONS-1:0]   RAM_POWERED,
	output logic      [RAM_SECTIONS-1:0]   RAM_RETAINED
);

	initial begin
		if (RAM_SECTIONS < 1 || RAM_SECTIONS > 8) begin
			$error("RAM_SECTIONS must be 1 to 8");
		end
	end

	// =====================================
	// Bus decode
	pmc_apb_req_t req;
	assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a[11:2] == ofs[11:2]);
	endfunction : hit

	wire logic access    = req.sel && req.enable;
	wire logic wr        = access && req.write;
	wire logic hit_fix   = hit(req.addr, OFS_FIXED_LAT_TASK);
	wire logic hit_eco   = hit(req.addr, OFS_ECONOMY_TASK);
	wire logic hit_cause = hit(req.addr, OFS_RESET_CAUSE);
	wire logic hit_sleep = hit(req.addr, OFS_DEEP_SLEEP);
	wire logic hit_sw    = hit(req.addr, OFS_SWITCHER_EN);
	wire logic hit_stat  = hit(req.addr, OFS_STATUS);

	logic [RAM_SECTIONS-1:0] hit_ram;
	logic [1:0]              ram_ctl_q [RAM_SECTIONS];
	logic [1:0]              ram_ctl_d [RAM_SECTIONS];

	// =====================================
	// State
	pmc_state_t state_q;
	pmc_state_t state_d;
	logic       switcher_enable_q;
	logic       fixed_latency_q;
	logic [3:0] reset_cause_q;
	logic [3:0] reset_cause_d;
	logic       wake_reset_q;
	logic       wake_in_debug_q;

	wire logic fixed_latency_task = wr && hit_fix && req.wdata[0];
	wire logic economy_mode_task  = wr && hit_eco && req.wdata[0];
	wire logic deep_sleep_command = wr && hit_sleep && req.wdata[0];
	wire logic debug_mode         = DEBUGGER_POWER_REQUEST;
	wire logic in_deep_off        = (state_q == PMC_DEEP_OFF);
	wire logic in_emulated        = (state_q == PMC_EMULATED);
	wire logic wake_sense         = PIN_SENSE && !in_deep_off ? 1'b0 : PIN_SENSE;
	wire logic wake_debug         = in_deep_off && debug_mode;
	wire logic wake_any           = in_deep_off && (PIN_SENSE || wake_debug);
	wire logic all_idle           = CPU_IDLE && PERIPH_IDLE && !in_deep_off;
	wire logic warm_reset         = PIN_RESET || SOFT_RESET;

	genvar g;
	generate
		for (g = 0; g < RAM_SECTIONS; g++) begin : g_ram
			localparam logic [11:0] OFS = 12'(OFS_RAM_POWER0 + g * OFS_RAM_STRIDE);
			assign hit_ram[g] = hit(req.addr, OFS);
			// Retained registers: only power-on resets them, to powered and retained
			assign ram_ctl_d[g] = (wr && hit_ram[g]) ? req.wdata[1:0] : ram_ctl_q[g];
			always_ff @(posedge CLK) begin
				if (POR) begin
					ram_ctl_q[g] <= RAM_POWER_RST;
				end else begin
					ram_ctl_q[g] <= ram_ctl_d[g];
				end
			end
			assign RAM_POWERED[g]  = ram_ctl_q[g][RAMP_POWER] && !in_deep_off;
			assign RAM_RETAINED[g] = ram_ctl_q[g][RAMP_RETAIN] || RAM_POWERED[g];
		end
	endgenerate

	// =====================================
	// Power state machine
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PMC_ON: begin
				if (deep_sleep_command) begin
					state_d = debug_mode ? PMC_EMULATED : PMC_DEEP_OFF;
				end
			end
			PMC_DEEP_OFF: begin
				if (wake_any) begin
					state_d = PMC_ON;
				end
			end
			PMC_EMULATED: begin
				if (PIN_SENSE) begin
					state_d = PMC_ON;
				end
			end
			default: state_d = PMC_ON;
		endcase
	end

	// Latest cause only; wake sources recorded over warm resets
	always_comb begin
		reset_cause_d = reset_cause_q;
		if (wake_any || (in_emulated && PIN_SENSE)) begin
			reset_cause_d = 4'h0;
			reset_cause_d[RC_WAKE_SENSE] = PIN_SENSE;
			reset_cause_d[RC_WAKE_DEBUG] = wake_debug && !PIN_SENSE;
		end else if (warm_reset) begin
			reset_cause_d = 4'h0;
			reset_cause_d[RC_PIN_RESET]  = PIN_RESET;
			reset_cause_d[RC_SOFT_RESET] = SOFT_RESET && !PIN_RESET;
		end else if (wr && hit_cause) begin
			reset_cause_d = reset_cause_q & ~req.wdata[3:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (POR) begin
			state_q <= PMC_ON;
			reset_cause_q <= RESET_CAUSE_RST;
		end else begin
			state_q <= state_d;
			reset_cause_q <= reset_cause_d;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST || POR) begin
			switcher_enable_q <= 1'b0;
			fixed_latency_q   <= 1'b0;
			wake_reset_q      <= 1'b0;
			wake_in_debug_q   <= 1'b0;
		end else begin
			if (wr && hit_sw) begin
				switcher_enable_q <= req.wdata[0];
			end
			if (wake_any || state_d != PMC_ON) begin
				fixed_latency_q <= 1'b0;
			end else if (economy_mode_task) begin
				fixed_latency_q <= 1'b0;
			end else if (fixed_latency_task) begin
				fixed_latency_q <= 1'b1;
			end
			wake_reset_q    <= wake_any || (in_emulated && PIN_SENSE);
			wake_in_debug_q <= debug_mode;
		end
	end

	// =====================================
	// Outputs
	pmc_power_t pwr;
	assign pwr.regulator_switcher = switcher_enable_q && !in_deep_off;
	assign pwr.fixed_latency      = fixed_latency_q;
	assign pwr.basic_resources_on = !in_deep_off && (!all_idle || fixed_latency_q
		|| PERIPH_ACTIVITY || in_emulated);
	assign pwr.core_power_on      = !in_deep_off;

	assign REGULATOR_SWITCHER = pwr.regulator_switcher;
	assign FIXED_LATENCY_MODE = pwr.fixed_latency;
	assign BASIC_RESOURCES_ON = pwr.basic_resources_on;
	assign CORE_POWER_ON      = pwr.core_power_on;
	assign TASK_ABORT         = in_deep_off || (state_q == PMC_ON && state_d == PMC_DEEP_OFF);
	assign SYSTEM_RESET       = wake_reset_q;
	assign DEBUG_PORT_RESET   = wake_reset_q && !wake_in_debug_q;
	assign DEBUG_MODE         = debug_mode;

	// =====================================
	// Read path
	logic [31:0] rdata;
	logic [RAM_SECTIONS-1:0] ram_sel;
	always_comb begin
		rdata = 32'h0000_0000;
		ram_sel = '0;
		if (hit_cause) begin
			rdata[3:0] = reset_cause_q;
		end else if (hit_sw) begin
			rdata[0] = switcher_enable_q;
		end else if (hit_stat) begin
			rdata[ST_SWITCHER]  = switcher_enable_q;
			rdata[ST_FIXED_LAT] = fixed_latency_q;
			rdata[ST_DEBUG]     = debug_mode;
			rdata[ST_EMULATED]  = in_emulated;
			rdata[ST_IDLE_OK]   = all_idle;
		end
		for (int i = 0; i < RAM_SECTIONS; i++) begin
			if (hit_ram[i]) begin
				rdata[1:0] = ram_ctl_q[i];
				ram_sel[i] = 1'b1;
			end
		end
	end

	wire logic mapped = hit_fix || hit_eco || hit_cause || hit_sleep || hit_sw
		|| hit_stat || (|hit_ram);

	assign PREADY  = 1'b1;
	assign PSLVERR = access && !mapped;

	always_ff @(posedge CLK) begin
		if (RST) begin
			PRDATA <= PSLVERR_NONE;
		end else if (req.sel && !req.enable && !req.write) begin
			PRDATA <= rdata;
		end
	end

	wire logic unused_ok = wake_sense ^ (|ram_sel);

endmodule : pmc_power_mode_controller

// [sim/pmc_power_mode_controller_monitor.sv]
`timescale 1ns/1ps
module pmc_mode_monitor
	import pmc_pkg::*;
#(
	parameter int RAM_SECTIONS = 3
) (
	input wire logic                    CLK,
	input wire logic                    RST,
	input wire logic                    POR,
	input wire logic                    PIN_SENSE,
	input wire logic                    DEBUGGER_POWER_REQUEST,
	input wire logic                    PSEL,
	input wire logic                    PENABLE,
	input wire logic                    PWRITE,
	input wire logic [11:0]             PADDR,
	input wire logic [31:0]             PWDATA,
	input wire logic                    REGULATOR_SWITCHER,
	input wire logic                    CORE_POWER_ON,
	input wire logic                    FIXED_LATENCY_MODE,
	input wire logic                    TASK_ABORT,
	input wire logic                    SYSTEM_RESET,
	input wire logic                    DEBUG_PORT_RESET,
	input wire logic                    DEBUG_MODE,
	input wire logic [RAM_SECTIONS-1:0] RAM_RETAINED
);
	// =====================================
	// Decoded writes
	wire acc_wr   = PSEL && PENABLE && PWRITE && PWDATA[0];
	wire sleep_wr = acc_wr && PADDR == OFS_DEEP_SLEEP;
	wire fix_wr   = acc_wr && PADDR == OFS_FIXED_LAT_TASK;
	wire eco_wr   = acc_wr && PADDR == OFS_ECONOMY_TASK;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST || POR);

	sequence off_s;
		!CORE_POWER_ON;
	endsequence
	sequence wake_s;
		off_s ##0 PIN_SENSE;
	endsequence

	// =====================================
	// Properties
	debug_follow_a: assert property (DEBUG_MODE == DEBUGGER_POWER_REQUEST)
		else $error("debug mode differs from request");
	enter_off_a: assert property (sleep_wr && !DEBUG_MODE |=> off_s)
		else $error("deep off not entered");
	emulate_a: assert property (sleep_wr && DEBUG_MODE |=> CORE_POWER_ON [*4])
		else $error("core power lost in emulation");
	abort_off_a: assert property (off_s |-> TASK_ABORT && !REGULATOR_SWITCHER)
		else $error("tasks or switcher alive in deep off");
	stay_off_a: assert property (off_s ##0 (!PIN_SENSE && !DEBUGGER_POWER_REQUEST) |=> off_s)
		else $error("deep off left without wake source");
	wake_reset_a: assert property (wake_s |-> ##[1:3] SYSTEM_RESET)
		else $error("wake without reset");
	reset_pulse_a: assert property (SYSTEM_RESET |=> !SYSTEM_RESET)
		else $error("reset pulse too long");
	dbg_port_a: assert property (SYSTEM_RESET && $past(DEBUG_MODE) |-> !DEBUG_PORT_RESET)
		else $error("debug port reset in debug mode");
	retain_keep_a: assert property (off_s ##1 off_s |-> $stable(RAM_RETAINED))
		else $error("retention changed in deep off");
	fixed_sel_a: assert property (fix_wr |=> FIXED_LATENCY_MODE)
		else $error("fixed latency not selected");
	economy_sel_a: assert property (eco_wr |=> !FIXED_LATENCY_MODE)
		else $error("economy mode not selected");
endmodule : pmc_mode_monitor

bind pmc_power_mode_controller pmc_mode_monitor #(.RAM_SECTIONS(RAM_SECTIONS)) u_mon (.*);

// [sim/test_power_mode_controller.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	$display("wrong value %s exp %h got %h", n, e, g); err_count++; end end
module test_power_mode_controller import pmc_pkg::*;;
	logic        clk = 0, rst = 1, por = 1, pin_rst = 0, sense = 0, dbg = 0;
	logic        cpu_idle = 0, per_idle = 0, psel = 0, pen = 0, pwr = 0, perr, per_act = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
	logic        pready, pslverr, sw, core, basic, fixed, abort, sys_rst, dp_rst, dmode;
	logic [2:0]  ram_p, ram_r;
	int          err_count = 0, num_checks = 0, cyc = 0;

	pmc_power_mode_controller #(.RAM_SECTIONS(3)) i_dut (.CLK(clk), .RST(rst), .POR(por),
		.PIN_RESET(pin_rst), .SOFT_RESET(1'b0), .PIN_SENSE(sense),
		.DEBUGGER_POWER_REQUEST(dbg), .CPU_IDLE(cpu_idle), .PERIPH_IDLE(per_idle),
		.PERIPH_ACTIVITY(per_act), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.REGULATOR_SWITCHER(sw), .CORE_POWER_ON(core), .BASIC_RESOURCES_ON(basic),
		.FIXED_LATENCY_MODE(fixed), .TASK_ABORT(abort), .SYSTEM_RESET(sys_rst),
		.DEBUG_PORT_RESET(dp_rst), .DEBUG_MODE(dmode), .RAM_POWERED(ram_p),
		.RAM_RETAINED(ram_r));

	always #2 clk = ~clk;

	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : test_done

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			test_done();
		end
	end

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic nap(input int n);
		repeat (n) @(negedge clk);
	endtask : nap

	// Wait for the wake reset pulse
	task automatic wake;
		for (int i = 0; i < 20 && sys_rst !== 1'b1; i++) @(negedge clk);
		`CHK("reset pulse", 1'b1, sys_rst)
	endtask : wake

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		nap(1);
		`CHK("switcher", 1'b0, sw)
		`CHK("fixed", 1'b0, fixed)
		`CHK("core", 1'b1, core)
		apb(0, OFS_RAM_POWER0, 32'h0000_0000);
		`CHK("ram0", 32'h0000_0003, rd)
		apb(1, OFS_SWITCHER_EN, 32'h0000_0001);
		nap(1);
		`CHK("switcher", 1'b1, sw)
		apb(1, OFS_FIXED_LAT_TASK, 32'h0000_0001);
		nap(1);
		`CHK("fixed", 1'b1, fixed)
		apb(1, OFS_ECONOMY_TASK, 32'h0000_0001);
		nap(1);
		`CHK("fixed", 1'b0, fixed)
		apb(1, OFS_FIXED_LAT_TASK, 32'h0000_0001);
		@(posedge clk);
		cpu_idle <= 1'b1;
		per_idle <= 1'b1;
		apb(0, OFS_STATUS, 32'h0000_0000);
		`CHK("status", 32'h0000_0013, rd)
		nap(1);
		`CHK("basic", 1'b1, basic)
		@(posedge clk);
		per_idle <= 1'b0;
		apb(0, OFS_STATUS, 32'h0000_0000);
		`CHK("status", 32'h0000_0003, rd)
		apb(1, OFS_ECONOMY_TASK, 32'h0000_0001);
		@(posedge clk);
		per_idle <= 1'b1;
		nap(1);
		`CHK("basic", 1'b0, basic)
		@(posedge clk);
		per_act <= 1'b1;
		nap(1);
		`CHK("basic", 1'b1, basic)
		@(posedge clk);
		per_act <= 1'b0;
		apb(1, OFS_RAM_POWER0 + OFS_RAM_STRIDE, 32'h0000_0002);
		nap(1);
		`CHK("ram pow", 1'b0, ram_p[1])
		`CHK("ram ret", 1'b1, ram_r[1])
		apb(0, 12'h004, 32'h0000_0000);
		`CHK("slverr", 1'b1, perr)
		`CHK("unmapped", 32'h0000_0000, rd)
		apb(1, OFS_DEEP_SLEEP, 32'h0000_0001);
		nap(1);
		`CHK("core", 1'b0, core)
		`CHK("abort", 1'b1, abort)
		`CHK("switcher", 1'b0, sw)
		nap(5);
		`CHK("core", 1'b0, core)
		@(posedge clk);
		sense <= 1'b1;
		wake();
		`CHK("port reset", 1'b1, dp_rst)
		@(posedge clk);
		sense <= 1'b0;
		nap(2);
		`CHK("core", 1'b1, core)
		`CHK("fixed", 1'b0, fixed)
		apb(0, OFS_RESET_CAUSE, 32'h0000_0000);
		`CHK("cause", 32'h0000_0004, rd)
		apb(0, OFS_RAM_POWER0 + OFS_RAM_STRIDE, 32'h0000_0000);
		`CHK("ram1", 32'h0000_0002, rd)
		apb(1, OFS_RESET_CAUSE, 32'h0000_000F);
		@(posedge clk);
		dbg <= 1'b1;
		nap(1);
		`CHK("debug", 1'b1, dmode)
		apb(1, OFS_DEEP_SLEEP, 32'h0000_0001);
		nap(2);
		`CHK("core", 1'b1, core)
		apb(0, OFS_STATUS, 32'h0000_0000);
		`CHK("emulated", 2'b11, rd[3:2])
		@(posedge clk);
		sense <= 1'b1;
		wake();
		`CHK("port reset", 1'b0, dp_rst)
		@(posedge clk);
		sense <= 1'b0;
		dbg <= 1'b0;
		nap(1);
		`CHK("debug", 1'b0, dmode)
		@(posedge clk);
		rst <= 1'b1;
		pin_rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		pin_rst <= 1'b0;
		apb(0, OFS_RESET_CAUSE, 32'h0000_0000);
		`CHK("cause", 32'h0000_0001, rd)
		`CHK("switcher", 1'b0, sw)
		test_done();
	end
endmodule : test_power_mode_controller
